// *** rtl/fcs_cmd_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
//==============================================================
// Command byte classifier
//==============================================================
module fcs_cmd_decode
    import fcs_pkg::*;
(
    fcs_cmd_if.decoder cmd                         // Code in, class out
);

    //==========================================================
    // Classification
    //==========================================================
    // Pure decode; the sequencer registers everything it keeps
    always_comb begin
        case (cmd.code)
            CMD_READ_ARRAY:        cmd.cls = CLS_READ_ARRAY;
            CMD_PGM_SETUP,
            CMD_PGM_SETUP_ALT:     cmd.cls = CLS_PGM_SETUP;
            CMD_ERS_SETUP:         cmd.cls = CLS_ERS_SETUP;
            CMD_EFP_SETUP:         cmd.cls = CLS_EFP_SETUP;
            CMD_CONFIRM:           cmd.cls = CLS_CONFIRM;
            CMD_SUSPEND:           cmd.cls = CLS_SUSPEND;
            CMD_CLEAR_STATUS:      cmd.cls = CLS_CLEAR_STATUS;
            CMD_LOCK_SETUP:        cmd.cls = CLS_LOCK_SETUP;
            CMD_LOCK_CONFIRM,
            CMD_LOCKDOWN_CONFIRM,
            CMD_CONFIG_CONFIRM:    cmd.cls = CLS_LOCK_CONFIRM;
            default:               cmd.cls = CLS_OTHER;   // Read status, ID and illegal codes
        endcase
    end

endmodule
`default_nettype wire

// *** rtl/fcs_write_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module fcs_write_sequencer
    import fcs_pkg::*;
(
    input  wire logic              core_clk_i,     // 200 MHz core clock
    input  wire logic              reset_i,        // Synchronous reset, active high
    input  wire logic              cmd_we_i,       // One-cycle bus write strobe
    input  wire logic [CODE_W-1:0] cmd_code_i,     // Command byte of the write
    input  wire logic [PART_W-1:0] cmd_part_i,     // Partition addressed by the write
    input  wire logic              op_done_i,      // Array operation complete pulse
    output var  fcs_state_e        state_o,        // Current sequencer state
    output logic                   busy_o,         // An array operation is running
    output logic                   suspended_o,    // In the program, erase or nested program suspend state
    output logic                   op_start_o,     // Pulse: start or resume array operation
    output logic [PART_W-1:0]      active_part_o,  // Partition owning the operation
    output logic                   error_o,        // Sticky command sequence error
    output logic                   lock_error_o    // Sticky lock sequence error
);

    //==========================================================
    // Declarations
    //==========================================================
    fcs_cmd_if   cmd_bus ();                       // Decoder link
    fcs_state_e  state_q;                          // Present state
    fcs_state_e  state_d;                          // Next state
    logic [PART_W-1:0] part_q;                     // Owning partition
    logic        error_q;                          // Sticky error
    logic        lock_error_q;                     // Sticky lock error
    logic        err_set;                          // Error event this cycle
    logic        lock_err_set;                     // Lock error event this cycle
    logic        start_q;                          // Registered start pulse
    logic        start_d;                          // Entering a busy state
    logic        owns_array;                       // State holds the single array slot

    assign cmd_bus.code = cmd_code_i;

    fcs_cmd_decode u_decode (
        .cmd (cmd_bus.decoder)
    );

    //==========================================================
    // Helpers
    //==========================================================
    // Any of the confirms that close a lock/configuration setup
    function automatic logic is_lock_confirm(input fcs_cmd_class_e c);
        return (c == CLS_LOCK_CONFIRM) || (c == CLS_CONFIRM);
    endfunction

    // States where an operation is running or parked
    function automatic logic is_active(input fcs_state_e s);
        return (s == ST_PGM_BUSY) || (s == ST_PGM_SUSP) || (s == ST_ERS_BUSY) || (s == ST_ERS_SUSP) ||
               (s == ST_PIES_BUSY) || (s == ST_PIES_SUSP) || (s == ST_EFP_BUSY) ||
               (s == ST_PIES_SETUP) || (s == ST_LOCK_SETUP_ES);
    endfunction

    //==========================================================
    // Next-state logic
    //==========================================================
    // Only bus writes move setup/suspend states; completion moves busy ones
    always_comb begin
        state_d      = state_q;
        err_set      = 1'b0;
        lock_err_set = 1'b0;
        start_d      = 1'b0;
        case (state_q)
            ST_READY: begin
                if (cmd_we_i) begin
                    case (cmd_bus.cls)
                        CLS_PGM_SETUP:  state_d = ST_PGM_SETUP;
                        CLS_ERS_SETUP:  state_d = ST_ERS_SETUP;
                        CLS_EFP_SETUP:  state_d = ST_EFP_SETUP;
                        CLS_LOCK_SETUP: state_d = ST_LOCK_SETUP;
                        default:        state_d = ST_READY;            // Read array and the rest
                    endcase
                end
            end
            ST_PGM_SETUP: begin
                // Data word of the program: any write launches it
                if (cmd_we_i) begin
                    state_d = ST_PGM_BUSY;
                    start_d = 1'b1;
                end
            end
            ST_PGM_BUSY: begin
                if (cmd_we_i && cmd_bus.cls == CLS_SUSPEND) begin
                    state_d = ST_PGM_SUSP;
                end else if (op_done_i) begin
                    state_d = ST_READY;
                end
            end
            ST_PGM_SUSP: begin
                // Everything but resume leaves the program parked
                if (cmd_we_i && cmd_bus.cls == CLS_CONFIRM) begin
                    state_d = ST_PGM_BUSY;
                    start_d = 1'b1;
                end
            end
            ST_ERS_SETUP: begin
                if (cmd_we_i) begin
                    if (cmd_bus.cls == CLS_CONFIRM) begin
                        state_d = ST_ERS_BUSY;
                        start_d = 1'b1;
                    end else begin
                        state_d = ST_READY;
                        err_set = 1'b1;
                    end
                end
            end
            ST_ERS_BUSY: begin
                if (cmd_we_i && cmd_bus.cls == CLS_SUSPEND) begin
                    state_d = ST_ERS_SUSP;
                end else if (op_done_i) begin
                    state_d = ST_READY;
                end
            end
            ST_ERS_SUSP: begin
                if (cmd_we_i) begin
                    case (cmd_bus.cls)
                        CLS_PGM_SETUP:  state_d = ST_PIES_SETUP;
                        CLS_LOCK_SETUP: state_d = ST_LOCK_SETUP_ES;
                        CLS_CONFIRM: begin
                            state_d = ST_ERS_BUSY;
                            start_d = 1'b1;
                        end
                        default:        state_d = ST_ERS_SUSP;
                    endcase
                end
            end
            ST_PIES_SETUP: begin
                if (cmd_we_i) begin
                    state_d = ST_PIES_BUSY;
                    start_d = 1'b1;
                end
            end
            ST_PIES_BUSY: begin
                if (cmd_we_i && cmd_bus.cls == CLS_SUSPEND) begin
                    state_d = ST_PIES_SUSP;
                end else if (op_done_i) begin
                    state_d = ST_ERS_SUSP;                              // Back to the parked erase
                end
            end
            ST_PIES_SUSP: begin
                if (cmd_we_i && cmd_bus.cls == CLS_CONFIRM) begin
                    state_d = ST_PIES_BUSY;
                    start_d = 1'b1;
                end
            end
            ST_EFP_SETUP: begin
                if (cmd_we_i) begin
                    if (cmd_bus.cls == CLS_CONFIRM) begin
                        state_d = ST_EFP_BUSY;
                        start_d = 1'b1;
                    end else begin
                        state_d = ST_READY;
                        err_set = 1'b1;
                    end
                end
            end
            ST_EFP_BUSY: begin
                // Data words stream in; only the completion pulse ends it
                if (op_done_i) begin
                    state_d = ST_READY;
                end
            end
            ST_LOCK_SETUP: begin
                if (cmd_we_i) begin
                    state_d      = ST_READY;
                    lock_err_set = !is_lock_confirm(cmd_bus.cls);
                end
            end
            ST_LOCK_SETUP_ES: begin
                if (cmd_we_i) begin
                    state_d      = ST_ERS_SUSP;
                    lock_err_set = !is_lock_confirm(cmd_bus.cls);
                end
            end
            default: begin
                state_d = ST_READY;
            end
        endcase
    end

    //==========================================================
    // State register
    //==========================================================
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= ST_READY;
        end else begin
            state_q <= state_d;
        end
    end

    //==========================================================
    // Partition ownership
    //==========================================================
    // Captured on every write in the ready state; a nested program
    // reuses the erase owner, so a second partition can never start
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            part_q <= PART_RESET;
        end else if (cmd_we_i && state_q == ST_READY && !is_active(state_d)) begin
            part_q <= cmd_part_i;
        end
    end

    //==========================================================
    // Sticky error flags
    //==========================================================
    // A new error beats a clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            error_q <= 1'b0;
        end else if (err_set) begin
            error_q <= 1'b1;
        end else if (cmd_we_i && cmd_bus.cls == CLS_CLEAR_STATUS && !owns_array) begin
            error_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lock_error_q <= 1'b0;
        end else if (lock_err_set) begin
            lock_error_q <= 1'b1;
        end else if (cmd_we_i && cmd_bus.cls == CLS_CLEAR_STATUS && !owns_array) begin
            lock_error_q <= 1'b0;
        end
    end

    //==========================================================
    // Start pulse
    //==========================================================
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end

    //==========================================================
    // Outputs
    //==========================================================
    assign owns_array    = is_active(state_q);
    assign state_o       = state_q;
    assign busy_o        = (state_q == ST_PGM_BUSY) || (state_q == ST_ERS_BUSY) ||
                           (state_q == ST_PIES_BUSY) || (state_q == ST_EFP_BUSY);
    assign suspended_o   = (state_q == ST_PGM_SUSP) || (state_q == ST_ERS_SUSP) || (state_q == ST_PIES_SUSP);
    assign op_start_o    = start_q;
    assign active_part_o = part_q;
    assign error_o       = error_q;
    assign lock_error_o  = lock_error_q;

    //==========================================================
    // Assertions
    //==========================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_wr(fcs_state_e s, fcs_cmd_class_e c);
        state_q == s && cmd_we_i && cmd_bus.cls == c;
    endsequence

    sequence s_pgm_parked;
        s_wr(ST_PGM_BUSY, CLS_SUSPEND) ##1 state_q == ST_PGM_SUSP;
    endsequence

    AST_ONE_OWNER: assert property (owns_array && $past(owns_array) |-> part_q == $past(part_q))
        else $error("Owning partition changed during an operation");
    AST_READY_HOLD: assert property (s_wr(ST_READY, CLS_READ_ARRAY) |=> state_q == ST_READY)
        else $error("Read array left the ready state");
    AST_SETUP_ENTRY: assert property (s_wr(ST_READY, CLS_ERS_SETUP) |=> state_q == ST_ERS_SETUP)
        else $error("Erase setup not entered from ready");
    AST_NESTED_START: assert property (state_q == ST_PIES_SETUP && cmd_we_i
                                       |=> state_q == ST_PIES_BUSY && op_start_o)
        else $error("Nested program did not start");
    AST_NESTED_SUSP: assert property (s_wr(ST_PIES_BUSY, CLS_SUSPEND) |=> state_q == ST_PIES_SUSP)
        else $error("Nested program suspend missed");
    AST_FAST_BAD: assert property (state_q == ST_EFP_SETUP && cmd_we_i && cmd_bus.cls != CLS_CONFIRM
                                   |=> state_q == ST_READY && error_o)
        else $error("Bad fast confirm did not flag error");
    AST_LOCK_BAD: assert property (state_q == ST_LOCK_SETUP_ES && cmd_we_i && cmd_bus.cls == CLS_OTHER
                                   |=> state_q == ST_ERS_SUSP && lock_error_o)
        else $error("Bad lock confirm in suspend not flagged");
    AST_PGM_PARK: assert property (s_pgm_parked ##0 !(cmd_we_i && cmd_bus.cls == CLS_CONFIRM)
                                   |=> state_q == ST_PGM_SUSP)
        else $error("Parked program left suspend without resume");
    AST_PGM_RESUME: assert property (s_wr(ST_PGM_SUSP, CLS_CONFIRM) |=> state_q == ST_PGM_BUSY ##1 busy_o)
        else $error("Resume did not restart the program");

endmodule
`default_nettype wire

// *** shared/fcs_cmd_if.sv ***
`timescale 1ns/10ps
`default_nettype none
//==============================================================
// Command byte and its decoded class
//==============================================================
interface fcs_cmd_if;
    import fcs_pkg::*;
    logic [CODE_W-1:0] code;                       // Raw command byte
    fcs_cmd_class_e    cls;                        // Decoded class
    modport decoder (input code, output cls);
    modport seq     (output code, input cls);
endinterface
`default_nettype wire

// *** shared/fcs_pkg.sv ***
//==============================================================
// Shared constants for the flash command sequencer
//==============================================================
package fcs_pkg;

    localparam int CODE_W = 8;                     // Command byte width on the bus
    localparam int PART_W = 3;                     // Partition select width

    //==========================================================
    // Command codes
    //==========================================================
    localparam logic [CODE_W-1:0] CMD_READ_ARRAY       = 8'hFF;  // Return to array read
    localparam logic [CODE_W-1:0] CMD_PGM_SETUP        = 8'h40;  // Word program setup
    localparam logic [CODE_W-1:0] CMD_PGM_SETUP_ALT    = 8'h10;  // Alternate program setup
    localparam logic [CODE_W-1:0] CMD_ERS_SETUP        = 8'h20;  // Block erase setup
    localparam logic [CODE_W-1:0] CMD_EFP_SETUP        = 8'h30;  // Factory fast program setup
    localparam logic [CODE_W-1:0] CMD_CONFIRM          = 8'hD0;  // Erase/fast confirm, resume, unlock
    localparam logic [CODE_W-1:0] CMD_SUSPEND          = 8'hB0;  // Program/erase suspend
    localparam logic [CODE_W-1:0] CMD_READ_STATUS      = 8'h70;  // Read status
    localparam logic [CODE_W-1:0] CMD_CLEAR_STATUS     = 8'h50;  // Clear error flags
    localparam logic [CODE_W-1:0] CMD_LOCK_SETUP       = 8'h60;  // Lock / configuration setup
    localparam logic [CODE_W-1:0] CMD_LOCK_CONFIRM     = 8'h01;  // Lock block confirm
    localparam logic [CODE_W-1:0] CMD_LOCKDOWN_CONFIRM = 8'h2F;  // Lock-down block confirm
    localparam logic [CODE_W-1:0] CMD_CONFIG_CONFIRM   = 8'h03;  // Write configuration_word confirm

    localparam logic [PART_W-1:0] PART_RESET = 3'h0;            // Partition register after reset

    //==========================================================
    // Types
    //==========================================================
    // Decoded command classes
    typedef enum logic [3:0] {
        CLS_READ_ARRAY,
        CLS_PGM_SETUP,
        CLS_ERS_SETUP,
        CLS_EFP_SETUP,
        CLS_CONFIRM,
        CLS_SUSPEND,
        CLS_CLEAR_STATUS,
        CLS_LOCK_SETUP,
        CLS_LOCK_CONFIRM,
        CLS_OTHER
    } fcs_cmd_class_e;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_READY,
        ST_PGM_SETUP,
        ST_PGM_BUSY,
        ST_PGM_SUSP,
        ST_ERS_SETUP,
        ST_ERS_BUSY,
        ST_ERS_SUSP,
        ST_PIES_SETUP,
        ST_PIES_BUSY,
        ST_PIES_SUSP,
        ST_EFP_SETUP,
        ST_EFP_BUSY,
        ST_LOCK_SETUP,
        ST_LOCK_SETUP_ES
    } fcs_state_e;

endpackage

// *** verification/fcs_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
//==============================================================
// Host side: issues command writes and completion pulses
//==============================================================
module fcs_host_model
    import fcs_pkg::*;
(
    input  wire logic              core_clk_i,  // Core clock
    output logic                   cmd_we_o,    // Write strobe
    output logic [CODE_W-1:0]      cmd_code_o,  // Command byte
    output logic [PART_W-1:0]      cmd_part_o,  // Partition of the write
    output logic                   op_done_o    // Array completion pulse
);
    localparam time SKEW = 1ns;                 // Drive delay after each edge

    // Quiet bus at time zero
    initial begin
        cmd_we_o   = 1'b0;
        cmd_code_o = 8'h00;
        cmd_part_o = 3'h0;
        op_done_o  = 1'b0;
    end

    // Holds one write through an edge; strobe stays up so writes chain
    task automatic wr(input logic [CODE_W-1:0] code, input logic [PART_W-1:0] part);
        cmd_we_o   = 1'b1;
        cmd_code_o = code;
        cmd_part_o = part;
        @(posedge core_clk_i);
        #SKEW;
    endtask

    // Released byte lines show the inverse, so stale data never matches
    task automatic idle(input int n);
        cmd_we_o   = 1'b0;
        cmd_code_o = ~cmd_code_o;
        cmd_part_o = ~cmd_part_o;
        repeat (n) begin
            @(posedge core_clk_i);
            #SKEW;
        end
    endtask

    // One-cycle completion pulse from the array
    task automatic done;
        op_done_o = 1'b1;
        @(posedge core_clk_i);
        #SKEW;
        op_done_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/tb_flash_command_state_machine.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
        end \
    end
//==============================================================
// Bench top
//==============================================================
module tb_flash_command_state_machine
    import fcs_pkg::*;
;
    logic              core_clk;                // 200 MHz clock
    logic              reset;                   // Synchronous reset
    logic              we;                      // Write strobe
    logic [CODE_W-1:0] code;                    // Command byte
    logic [PART_W-1:0] part;                    // Partition
    logic              done;                    // Completion pulse
    fcs_state_e        state;                   // Sequencer state
    logic              busy, susp, start;       // Status levels and pulse
    logic [PART_W-1:0] apart;                   // Owning partition
    logic              err, lerr;               // Sticky errors
    int                error_cnt = 0;           // Mismatches
    int                checked   = 0;           // Comparisons

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    fcs_host_model i_host (.core_clk_i(core_clk), .cmd_we_o(we), .cmd_code_o(code),
                           .cmd_part_o(part), .op_done_o(done));
    fcs_write_sequencer i_dut (.core_clk_i(core_clk), .reset_i(reset), .cmd_we_i(we),
        .cmd_code_i(code), .cmd_part_i(part), .op_done_i(done), .state_o(state),
        .busy_o(busy), .suspended_o(susp), .op_start_o(start), .active_part_o(apart),
        .error_o(err), .lock_error_o(lerr));

    //==========================================================
    // Shared tasks
    //==========================================================
    // Prints counts and verdict, ends the run
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reset for three edges, released just after an edge
    task automatic do_reset;
        reset = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        reset = 1'b0;
    endtask

    // Start pulse rises with the busy state and lasts one cycle only
    task automatic chk_start;
        `CHK("start_pulse", 1'b1, start)
        i_host.idle(1);
        `CHK("start_after", 1'b0, start)
    endtask

    //==========================================================
    // Scenarios
    //==========================================================
    // Reset values of every output
    task automatic t_reset;
        do_reset();
        `CHK("rst_state", ST_READY, state)
        `CHK("rst_flags", 5'h00, {busy, susp, start, err, lerr})
        `CHK("rst_part", PART_RESET, apart)
    endtask

    // Ready: read array stays, each program, erase and fast setup code enters its setup state
    task automatic t_ready;
        logic [CODE_W-1:0] codes [4] = '{CMD_PGM_SETUP, CMD_PGM_SETUP_ALT, CMD_ERS_SETUP, CMD_EFP_SETUP};
        fcs_state_e        sts   [4] = '{ST_PGM_SETUP, ST_PGM_SETUP, ST_ERS_SETUP, ST_EFP_SETUP};
        for (int i = 0; i < 4; i++) begin
            do_reset();
            i_host.wr(CMD_READ_ARRAY, 3'h0);
            `CHK("ffh_ready", ST_READY, state)
            i_host.wr(codes[i], 3'(i + 1));
            `CHK("setup_state", sts[i], state)
            `CHK("setup_part", 3'(i + 1), apart)
            i_host.idle(1);
        end
    endtask

    // Program, second operation refused, suspend and resume
    task automatic t_program;
        do_reset();
        i_host.wr(CMD_PGM_SETUP, 3'h3);
        i_host.wr(8'h5A, 3'h3);
        `CHK("pgm_busy", ST_PGM_BUSY, state)
        `CHK("pgm_part", 3'h3, apart)
        chk_start();
        i_host.wr(CMD_ERS_SETUP, 3'h6);
        `CHK("second_op", ST_PGM_BUSY, state)
        `CHK("owner_kept", 3'h3, apart)
        i_host.wr(CMD_SUSPEND, 3'h6);
        `CHK("pgm_susp", ST_PGM_SUSP, state)
        `CHK("susp_lvl", 2'b01, {busy, susp})
        i_host.wr(CMD_PGM_SETUP, 3'h6);
        `CHK("susp_hold", ST_PGM_SUSP, state)
        i_host.wr(CMD_CONFIRM, 3'h3);
        `CHK("pgm_resume", ST_PGM_BUSY, state)
        chk_start();
        i_host.done();
        `CHK("pgm_end", ST_READY, state)
        `CHK("pgm_noerr", 1'b0, err)
    endtask

    // Fast program: confirm runs, anything else errors; erase and lock setup errors from ready
    task automatic t_fast;
        do_reset();
        i_host.wr(CMD_EFP_SETUP, 3'h2);
        i_host.wr(CMD_CONFIRM, 3'h2);
        `CHK("efp_busy", ST_EFP_BUSY, state)
        chk_start();
        i_host.wr(CMD_PGM_SETUP, 3'h2);
        `CHK("efp_ignore", ST_EFP_BUSY, state)
        i_host.idle(1);
        i_host.done();
        `CHK("efp_end", ST_READY, state)
        i_host.wr(CMD_EFP_SETUP, 3'h2);
        i_host.wr(8'h77, 3'h2);
        `CHK("efp_bad", ST_READY, state)
        `CHK("efp_err", 1'b1, err)
        i_host.wr(CMD_CLEAR_STATUS, 3'h0);
        `CHK("err_clear", 1'b0, err)
        i_host.wr(CMD_ERS_SETUP, 3'h4);
        i_host.wr(CMD_READ_ARRAY, 3'h4);
        `CHK("ers_bad", ST_READY, state)
        `CHK("ers_err", 1'b1, err)
        i_host.wr(CMD_LOCK_SETUP, 3'h1);
        i_host.wr(CMD_CONFIG_CONFIRM, 3'h1);
        `CHK("lock_ok_state", ST_READY, state)
        `CHK("lock_ok_err", 1'b0, lerr)
        i_host.wr(CMD_LOCK_SETUP, 3'h1);
        i_host.wr(8'h77, 3'h1);
        `CHK("lock_rdy", ST_READY, state)
        `CHK("lock_rdy_err", 1'b1, lerr)
        i_host.idle(1);
    endtask

    // Erase suspend: bad lock confirm, nested program and its suspend
    task automatic t_erase;
        do_reset();
        i_host.wr(CMD_ERS_SETUP, 3'h5);
        i_host.wr(CMD_CONFIRM, 3'h5);
        `CHK("ers_busy", ST_ERS_BUSY, state)
        i_host.wr(CMD_SUSPEND, 3'h5);
        `CHK("ers_susp", ST_ERS_SUSP, state)
        i_host.wr(CMD_LOCK_SETUP, 3'h5);
        i_host.wr(CMD_LOCKDOWN_CONFIRM, 3'h5);
        `CHK("lock_good", ST_ERS_SUSP, state)
        `CHK("lock_good_err", 1'b0, lerr)
        i_host.wr(CMD_LOCK_SETUP, 3'h5);
        `CHK("lock_es", ST_LOCK_SETUP_ES, state)
        i_host.wr(8'h77, 3'h5);
        `CHK("lock_back", ST_ERS_SUSP, state)
        `CHK("lock_err", 1'b1, lerr)
        i_host.wr(CMD_CLEAR_STATUS, 3'h5);
        `CHK("clear_refused", 1'b1, lerr)
        i_host.wr(CMD_PGM_SETUP, 3'h2);
        `CHK("pies_setup", ST_PIES_SETUP, state)
        i_host.wr(CMD_READ_ARRAY, 3'h2);
        `CHK("pies_busy", ST_PIES_BUSY, state)
        `CHK("pies_owner", 3'h5, apart)
        i_host.wr(CMD_SUSPEND, 3'h2);
        `CHK("pies_susp", ST_PIES_SUSP, state)
        i_host.wr(CMD_CONFIRM, 3'h2);
        `CHK("pies_resume", ST_PIES_BUSY, state)
        i_host.idle(1);
        i_host.done();
        `CHK("pies_end", ST_ERS_SUSP, state)
        i_host.wr(CMD_CONFIRM, 3'h5);
        `CHK("ers_resume", ST_ERS_BUSY, state)
        i_host.idle(1);
        i_host.done();
        `CHK("ers_end", ST_READY, state)
    endtask

    //==========================================================
    // Main sequence and hang guard
    //==========================================================
    initial begin
        reset = 1'b1;
        t_reset();
        t_ready();
        t_program();
        t_fast();
        t_erase();
        final_report();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end
endmodule
`undef CHK
`default_nettype wire
